// File: logic/pwc_top.sv
// Shared PWM cycle configuration register with overflow flag and reload steering.
`timescale 1ns/10ps
`include "pwc_defines.svh"
module pwc_top (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire pwc_pkg::pwc_sfr_t sfr_in,
   input wire logic [15:0] counter_in,
   input wire logic [5:0] wide_pwm_select_in,
   input wire logic [5:0] pwm_enable_in,
   output logic [7:0] rdata_out,
   output logic rsel_out,
   output logic reload_access_out,
   output logic [5:0] shared_len_active_out,
   output pwc_pkg::pwc_len_t cycle_len_out,
   output logic cycle_overflow_flag_out,
   output logic irq_out
);
   import pwc_pkg::*;
   pwc_cfg_t cfg_q;
   pwc_cfg_t cfg_d;
   logic [15:0] count_prev_q;
   logic hit;
   logic wr_hit;
   logic carry;
   logic step;
   logic [7:0] wdata_m;
   logic rd_hit;
   logic [7:0] rdata_d;
   // Page check matters: the same address on page zero is a different register.
   assign hit = (sfr_in.addr == `PWC_CFG_ADDR) && (sfr_in.page == `PWC_CFG_PAGE);
   assign wr_hit = sfr_in.wr && hit;
   assign rd_hit = sfr_in.rd && hit;
   assign rdata_d = rd_hit ? 8'(cfg_q) : 8'h00;
   assign step = counter_in != count_prev_q[15:0];
   assign wdata_m = sfr_in.wdata & `PWC_CFG_WMASK;
   pwc_ovf_detect u_ovf (
      .count_in(counter_in[10:0]),
      .count_prev_in(count_prev_q[10:0]),
      .count_step_in(step),
      .len_in(cfg_q.cycle_length_select),
      .carry_out(carry)
   );
   always_comb begin
      cfg_d = cfg_q;
      if (wr_hit) begin
         cfg_d = pwc_cfg_t'(wdata_m);
      end
      // Hardware set wins over a software clear in the same cycle.
      if (carry) begin
         cfg_d.cycle_overflow_flag = 1'b1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cfg_q <= pwc_cfg_t'(`PWC_CFG_RESET);
         count_prev_q <= 16'h0000;
      end else begin
         cfg_q <= cfg_d;
         count_prev_q <= counter_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rdata_d;
      end
   end
   // Compare-register decoding lives with the modules; this block only steers.
   assign rsel_out = cfg_q.reload_register_select;
   // Reload storage only acts when reload select is set and the shared length is above 8 bits.
   assign reload_access_out = cfg_q.reload_register_select &&
      (cfg_q.cycle_length_select != PWC_LEN8);
   assign shared_len_active_out = pwm_enable_in & ~wide_pwm_select_in;
   assign cycle_len_out = cfg_q.cycle_length_select;
   assign cycle_overflow_flag_out = cfg_q.cycle_overflow_flag;
   assign irq_out = cfg_q.cycle_overflow_flag & cfg_q.cycle_overflow_irq_enable;


   // A wrap is two steps: the low field full of ones, then the next count clearing it.
   sequence s_len8_full;
      (cycle_len_out == PWC_LEN8) && (counter_in[7:0] == 8'hff);
   endsequence
   sequence s_len8_wrap;
      (cycle_len_out == PWC_LEN8) && (counter_in[7:0] == 8'h00);
   endsequence
   sequence s_len9_full;
      (cycle_len_out == PWC_LEN9) && (counter_in[8:0] == 9'h1ff);
   endsequence
   sequence s_len9_wrap;
      (cycle_len_out == PWC_LEN9) && (counter_in[8:0] == 9'h000);
   endsequence
   sequence s_len10_full;
      (cycle_len_out == PWC_LEN10) && (counter_in[9:0] == 10'h3ff);
   endsequence
   sequence s_len10_wrap;
      (cycle_len_out == PWC_LEN10) && (counter_in[9:0] == 10'h000);
   endsequence
   sequence s_len11_full;
      (cycle_len_out == PWC_LEN11) && (counter_in[10:0] == 11'h7ff);
   endsequence
   sequence s_len11_wrap;
      (cycle_len_out == PWC_LEN11) && (counter_in[10:0] == 11'h000);
   endsequence
   sequence s_len9_half;
      (cycle_len_out == PWC_LEN9) && (counter_in[8:0] == 9'h0ff);
   endsequence
   sequence s_len9_bit8;
      (cycle_len_out == PWC_LEN9) && (counter_in[8:0] == 9'h100);
   endsequence

   a_irq_follows: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wr_hit && sfr_in.wdata[`PWC_BIT_IRQEN] && sfr_in.wdata[`PWC_BIT_FLAG]) |=> irq_out)
      else $error("interrupt not raised by enabled flag");
   a_irq_masked: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wr_hit && !sfr_in.wdata[`PWC_BIT_IRQEN]) |=> !irq_out)
      else $error("interrupt raised with enable clear");
   a_irq_on_carry: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (carry && !wr_hit && cfg_q.cycle_overflow_irq_enable) |=> irq_out)
      else $error("overflow with enable set raised no interrupt");
   a_flag_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
      carry |=> cycle_overflow_flag_out)
      else $error("overflow did not set flag");
   a_flag_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cycle_overflow_flag_out && !wr_hit) |=> cycle_overflow_flag_out)
      else $error("flag cleared without software write");
   a_flag_sw_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wr_hit && sfr_in.wdata[`PWC_BIT_FLAG]) |=> cycle_overflow_flag_out)
      else $error("software write of one did not set flag");
   a_flag_sw_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wr_hit && !sfr_in.wdata[`PWC_BIT_FLAG] && !carry) |=> !cycle_overflow_flag_out)
      else $error("software write of zero did not clear flag");
   a_flag_no_cause: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (!cycle_overflow_flag_out && !carry && !wr_hit) |=> !cycle_overflow_flag_out)
      else $error("flag set without overflow or write");
   a_unused_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
      rdata_out[4:2] == 3'b000)
      else $error("unused bits read nonzero");
   a_unused_store: assert property (@(posedge clk_in) disable iff (!resetn_in)
      cfg_q.unused == 3'b000)
      else $error("unused bits stored nonzero");
   a_page_decode: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sfr_in.wr && sfr_in.page != `PWC_CFG_PAGE && !carry) |=> $stable(cfg_q))
      else $error("write on wrong page changed register");
   a_read_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
      rd_hit |=> (rdata_out == 8'($past(cfg_q))))
      else $error("read data does not match register");
   a_read_miss: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !rd_hit |=> (rdata_out == 8'h00))
      else $error("read data nonzero without decoded read");
   a_write_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
      wr_hit |=> cycle_len_out == pwc_len_t'($past(sfr_in.wdata[1:0])))
      else $error("length field not written");
   a_len_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !wr_hit |=> $stable(cycle_len_out))
      else $error("length field changed without write");
   a_reload_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
      wr_hit |=> rsel_out == $past(sfr_in.wdata[7]))
      else $error("reload select not written");
   a_rsel_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !wr_hit |=> $stable(rsel_out))
      else $error("reload select changed without write");
   a_reload_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !rsel_out |-> !reload_access_out)
      else $error("reload access without reload select");
   a_wide_mask: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wide_pwm_select_in[0]) |-> !shared_len_active_out[0])
      else $error("wide channel uses shared length");
   a_shared_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (pwm_enable_in[5] && !wide_pwm_select_in[5]) |-> shared_len_active_out[5])
      else $error("narrow channel misses shared length");
   a_pwm_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !pwm_enable_in[1] |-> !shared_len_active_out[1])
      else $error("channel without pwm uses shared length");
   a_reload_len8: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cycle_len_out == PWC_LEN8) |-> !reload_access_out)
      else $error("reload active in 8-bit mode");
   a_reload_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (rsel_out && (cycle_len_out != PWC_LEN8)) |-> reload_access_out)
      else $error("reload access missing for longer cycle");
   a_step_needed: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (counter_in == count_prev_q) |-> !carry)
      else $error("carry seen without a count step");
   a_wrap8_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_len8_full ##1 s_len8_wrap |=> cycle_overflow_flag_out)
      else $error("8-bit wrap did not set flag");
   a_wrap9_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_len9_full ##1 s_len9_wrap |=> cycle_overflow_flag_out)
      else $error("9-bit wrap did not set flag");
   a_wrap10_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_len10_full ##1 s_len10_wrap |=> cycle_overflow_flag_out)
      else $error("10-bit wrap did not set flag");
   a_wrap11_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_len11_full ##1 s_len11_wrap |=> cycle_overflow_flag_out)
      else $error("11-bit wrap did not set flag");
   a_no_early_carry: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_len9_half ##1 s_len9_bit8 |-> !carry)
      else $error("carry out of bit 8 in 9-bit cycle");
endmodule : pwc_top

// File: logic/pwc_defines.svh
// Constants for the shared PWM cycle configuration block.
// How it works
// - Reload select bit steers compare high/low accesses to reload or compare storage.
// - Reload registers only feed 9, 10 and 11-bit PWM cycles.
// - Interrupt request while overflow flag and its enable are both set.
// - Overflow flag sets when counter carries out of the selected bit 8-11.
// - Flag set by hardware or software one; only software clears it.
// - Bits 4:2 read zero and ignore writes.
// - Length code 00 gives 8 bits, 01 gives 9, 10 gives 10.
// - One length setting serves all non-16-bit PWM channels.
// - Register decodes at address 0xd9 only on page 0x0f.
// - Per-module wide select bit chooses 16-bit PWM over shared length.
`ifndef PWC_DEFINES_SVH
`define PWC_DEFINES_SVH
`define PWC_CFG_ADDR 8'hd9
`define PWC_CFG_PAGE 8'h0f
`define PWC_CFG_RESET 8'h00
`define PWC_BIT_RELOAD_REGISTER_SELECT 7
`define PWC_BIT_IRQEN 6
`define PWC_BIT_FLAG 5
`define PWC_CFG_WMASK 8'he3
`define PWC_NUM_MOD 6
`endif

// File: logic/pwc_pkg.sv
// Types for the shared PWM cycle configuration block.
package pwc_pkg;
   typedef enum logic [1:0] {
      PWC_LEN8 = 2'b00,
      PWC_LEN9 = 2'b01,
      PWC_LEN10 = 2'b10,
      PWC_LEN11 = 2'b11
   } pwc_len_t;
   typedef struct packed {
      logic reload_register_select;
      logic cycle_overflow_irq_enable;
      logic cycle_overflow_flag;
      logic [2:0] unused;
      pwc_len_t cycle_length_select;
   } pwc_cfg_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] page;
      logic [7:0] wdata;
   } pwc_sfr_t;
endpackage : pwc_pkg

// File: logic/pwc_ovf_detect.sv
// Carry detector for the selected PWM cycle length.
`timescale 1ns/10ps
module pwc_ovf_detect (
   input wire logic [10:0] count_in,
   input wire logic [10:0] count_prev_in,
   input wire logic count_step_in,
   input wire pwc_pkg::pwc_len_t len_in,
   output logic carry_out
);
   import pwc_pkg::*;
   logic [3:0] width;
   logic [10:0] mask;
   function automatic logic [3:0] len_bits(input pwc_len_t l);
      unique case (l)
         PWC_LEN8: len_bits = 4'h8;
         PWC_LEN9: len_bits = 4'h9;
         PWC_LEN10: len_bits = 4'ha;
         PWC_LEN11: len_bits = 4'hb;
      endcase
   endfunction : len_bits
   assign width = len_bits(len_in);
   assign mask = 11'((12'h001 << width) - 12'h001);
   // A carry out of the selected bit leaves the low field wrapped to zero.
   assign carry_out = count_step_in && ((count_in & mask) == 11'h000) &&
      ((count_prev_in & mask) == mask);
endmodule : pwc_ovf_detect

// File: tb/tb_pwc_top.sv
// Self-checking bench for the shared PWM cycle configuration block.
`timescale 1ns/10ps
module tb_pwc_top;
   import pwc_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   pwc_sfr_t sfr_in = '0;
   logic [15:0] counter_in = 16'h0000;
   logic [5:0] wide_pwm_select_in = 6'h0f;
   logic [5:0] pwm_enable_in = 6'h2d;
   logic [7:0] rdata_out;
   logic rsel_out, reload_access_out, cycle_overflow_flag_out, irq_out;
   logic [5:0] shared_len_active_out;
   pwc_len_t cycle_len_out;
   int errors = 0;
   int n_compared = 0;
   logic [1:0] kk;
   logic ra;
   // Status packs the register-driven outputs so one compare covers them all.
   wire [7:0] st = {2'h0, rsel_out, reload_access_out, cycle_overflow_flag_out, irq_out,
      cycle_len_out};
   always #12.5 clk_in = ~clk_in;
   pwc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_in(sfr_in),
      .counter_in(counter_in), .wide_pwm_select_in(wide_pwm_select_in),
      .pwm_enable_in(pwm_enable_in), .rdata_out(rdata_out), .rsel_out(rsel_out),
      .reload_access_out(reload_access_out), .shared_len_active_out(shared_len_active_out),
      .cycle_len_out(cycle_len_out), .cycle_overflow_flag_out(cycle_overflow_flag_out),
      .irq_out(irq_out));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One access pulse; returns after the taking edge so results have landed.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p,
      input logic [7:0] d);
      @(negedge clk_in);
      sfr_in = '{wr: w, rd: ~w, addr: a, page: p, wdata: d};
      @(negedge clk_in);
      sfr_in = '0;
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
      acc(1'b0, a, p, 8'h00);
      check(rdata_out, exp);
   endtask : rd
   // Two edges allow for the registered previous count that pwc_top feeds the detector.
   task automatic step(input logic [15:0] v);
      @(negedge clk_in);
      counter_in = v;
      repeat (2) @(negedge clk_in);
   endtask : step
   task automatic conclude();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      #100000;
      errors++;
      conclude();
   end
   initial begin
      repeat (10) @(negedge clk_in);
      resetn_in = 1'b1;
      check(st, 8'h00);
      rd(8'hd9, 8'h0f, 8'h00);
      check({2'h0, shared_len_active_out}, 8'h20);
      wide_pwm_select_in = 6'h00;
      #1 check({2'h0, shared_len_active_out}, 8'h2d);
      acc(1'b1, 8'hd9, 8'h0f, 8'hff);
      rd(8'hd9, 8'h0f, 8'he3);
      check(st, 8'h3f);
      acc(1'b1, 8'hd9, 8'h00, 8'h00);
      acc(1'b1, 8'hda, 8'h0f, 8'h00);
      rd(8'hd9, 8'h0f, 8'he3);
      rd(8'hd9, 8'h00, 8'h00);
      rd(8'hda, 8'h0f, 8'h00);
      acc(1'b1, 8'hd9, 8'h0f, 8'h20);
      check(st, 8'h08);
      $display("Register access tests done");
      for (int k = 0; k < 4; k++) begin
         kk = k[1:0];
         ra = (kk != 2'h0);
         acc(1'b1, 8'hd9, 8'h0f, {6'h30, kk});
         check(st, {3'h1, ra, 2'h0, kk});
         step((16'h0001 << (7 + k)) - 16'h0001);
         step(16'h0001 << (7 + k));
         check(st, {3'h1, ra, 2'h0, kk});
         step((16'h0001 << (8 + k)) - 16'h0001);
         step(16'h0001 << (8 + k));
         check(st, {3'h1, ra, 2'h3, kk});
         step(counter_in + 16'h0001);
         check(st, {3'h1, ra, 2'h3, kk});
      end
      $display("Cycle overflow tests done");
      acc(1'b1, 8'hd9, 8'h0f, 8'hc3);
      check(st, 8'h33);
      step(16'h0fff);
      // A clear that lands on the overflow edge must lose to the hardware set.
      counter_in = 16'h1000;
      sfr_in = '{wr: 1'b1, rd: 1'b0, addr: 8'hd9, page: 8'h0f, wdata: 8'hc3};
      @(negedge clk_in);
      sfr_in = '0;
      check(st, 8'h3f);
      resetn_in = 1'b0;
      @(negedge clk_in);
      resetn_in = 1'b1;
      check(st, 8'h00);
      rd(8'hd9, 8'h0f, 8'h00);
      $display("Set priority and reset tests done");
      conclude();
   end
endmodule : tb_pwc_top
